//--- logic/modbus_exc_pkg.sv
package modbus_exc_pkg;

    // Byte-oriented framing constants
    localparam int          BYTE_W         = 8;
    localparam int          CRC_W          = 16;
    localparam logic [7:0]  EXC_FLAG       = 8'h80;
    localparam logic [7:0]  FC_FILE_RECORD = 8'h14;
    localparam logic [15:0] CRC_INIT       = 16'hFFFF;
    localparam logic [15:0] CRC_POLY       = 16'hA001;

    // Exception codes carried in the data field
    localparam logic [7:0]  EXC_ILLEGAL_FUNC  = 8'h01;
    localparam logic [7:0]  EXC_ILLEGAL_ADDR  = 8'h02;
    localparam logic [7:0]  EXC_ILLEGAL_VALUE = 8'h03;
    localparam logic [7:0]  EXC_DEVICE_FAIL   = 8'h04;
    localparam logic [7:0]  EXC_DEVICE_BUSY   = 8'h06;
    localparam logic [7:0]  EXC_NEG_ACK       = 8'h07;
    localparam logic [7:0]  EXC_BUF_OVERFLOW  = 8'h09;

    // Decoded query as handed over by the frame receiver
    typedef struct packed {
        logic [7:0] slaveAddr;
        logic [7:0] funcCode;
        logic       commError;
        logic       illegalFunc;
        logic       badAddress;
        logic       badValue;
        logic       deviceFail;
        logic       devBusy;
        logic       cannotProcess;
        logic       bufferOverflow;
    } query_s;

    // Reply sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_FUNC,
        ST_CODE,
        ST_PAY,
        ST_CRCLO,
        ST_CRCHI
    } state_e;

endpackage : modbus_exc_pkg

//--- logic/modbus_crc16.sv
`timescale 1ns/1ps

module modbus_crc16
    import modbus_exc_pkg::*;
#(
    parameter int DATA_W = BYTE_W
)
(
    input  wire logic                sys_clk,
    input  wire logic                reset_n,
    input  wire logic                init,
    input  wire logic                update,
    input  wire logic [DATA_W-1:0]   dataIn,
    output logic      [CRC_W-1:0]    crcNext,
    output logic      [CRC_W-1:0]    crcVal
);

    logic [CRC_W-1:0] crc_reg;
    logic [CRC_W-1:0] stage [0:DATA_W];

    // Refuse widths the shift chain cannot pad
    if (DATA_W < 1 || DATA_W >= CRC_W)
    begin : g_bad_width
        $error("modbus_crc16: DATA_W must be 1 to 15");
    end

    // Reflected polynomial, one shift per data bit
    assign stage[0] = crc_reg ^ {{(CRC_W-DATA_W){1'b0}}, dataIn};
    for (genvar i = 0; i < DATA_W; i++)
    begin : g_shift
        assign stage[i+1] = stage[i][0] ? ((stage[i] >> 1) ^ CRC_POLY)
                                        : (stage[i] >> 1);
    end
    assign crcNext = stage[DATA_W];
    assign crcVal  = crc_reg;

    // Running remainder, restarted for each reply
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            crc_reg <= CRC_INIT;
        else if (init)
            crc_reg <= CRC_INIT;
        else if (update)
            crc_reg <= crcNext;
    end

endmodule : modbus_crc16

//--- logic/modbus_slave_exception_responder.sv
// Functional notes
// - Normal reply echoes the query function code
// - Corrupted query is dropped with no reply
// - Exception reply returns function code plus 80h
// - Exception data field holds one code only
// - Code 01 for a function not permitted
// - Code 02 for a nonexistent coil or register
// - Code 03 for a value out of range
// - Code 04 for a bad internal device state
// - Code 06 when busy; master retries later
// - Code 07 as negative acknowledge
// - Code 09 on buffer overflow, function 20
// - Failed read-03 replies address, 83, 04, CRC
`timescale 1ns/1ps

module modbus_slave_exception_responder
    import modbus_exc_pkg::*;
(
    input  wire logic          sys_clk,
    input  wire logic          reset_n,
    input  wire query_s        query,
    input  wire logic          queryValid,
    output logic               queryReady,
    input  wire logic [7:0]    payData,
    input  wire logic          payValid,
    input  wire logic          payLast,
    output logic               payReady,
    output logic [7:0]         txData,
    output logic               txValid,
    output logic               txLast,
    input  wire logic          txReady,
    output logic               queryDropped
);

    state_e     state_reg;
    logic [7:0] txData_reg;
    logic       txValid_reg;
    logic [7:0] addr_reg;
    logic [7:0] func_reg;
    logic [7:0] code_reg;
    logic       exc_reg;
    logic       payLast_reg;
    logic       dropped_reg;
    logic       qryAcc;
    logic       fire;
    logic       qryExc;
    logic [7:0] qryCode;
    logic [15:0] crcNext;
    logic [15:0] crcVal;

    // Exception choice; first matching condition wins
    function automatic logic [7:0] pickCode(input query_s q);
        logic [7:0] c;
        c = EXC_DEVICE_FAIL;
        if (q.illegalFunc || q.funcCode[7])
            c = EXC_ILLEGAL_FUNC;
        else if (q.badAddress)
            c = EXC_ILLEGAL_ADDR;
        else if (q.badValue)
            c = EXC_ILLEGAL_VALUE;
        else if (q.bufferOverflow && q.funcCode == FC_FILE_RECORD)
            c = EXC_BUF_OVERFLOW;
        else if (q.devBusy)
            c = EXC_DEVICE_BUSY;
        else if (q.cannotProcess)
            c = EXC_NEG_ACK;
        return c;
    endfunction : pickCode

    // Handshake terms
    assign queryReady = (state_reg == ST_IDLE);
    assign qryAcc     = queryValid && queryReady;
    assign fire       = txValid_reg && txReady;
    assign payReady   = (state_reg == ST_PAY) && !txValid_reg;
    assign txData     = txData_reg;
    assign txValid    = txValid_reg;
    assign txLast     = (state_reg == ST_CRCHI);
    assign queryDropped = dropped_reg;
    assign qryCode    = pickCode(query);
    // overflow counts only for function 20
    assign qryExc = query.illegalFunc || query.funcCode[7]
                 || query.badAddress || query.badValue
                 || (query.bufferOverflow && query.funcCode == FC_FILE_RECORD)
                 || query.deviceFail || query.devBusy || query.cannotProcess;

    // Reply sequencer
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            state_reg <= ST_IDLE;
        else
            unique case (state_reg)
                ST_IDLE:  if (qryAcc && !query.commError)
                              state_reg <= ST_ADDR;
                ST_ADDR:  if (fire)
                              state_reg <= ST_FUNC;
                ST_FUNC:  if (fire)
                              state_reg <= exc_reg ? ST_CODE : ST_PAY;
                ST_CODE:  if (fire)
                              state_reg <= ST_CRCLO;
                ST_PAY:   if (fire && payLast_reg)
                              state_reg <= ST_CRCLO;
                ST_CRCLO: if (fire)
                              state_reg <= ST_CRCHI;
                ST_CRCHI: if (fire)
                              state_reg <= ST_IDLE;
            endcase
    end

    // Query capture at acceptance
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            addr_reg <= 8'h00;
            func_reg <= 8'h00;
            code_reg <= 8'h00;
            exc_reg  <= 1'b0;
        end
        else if (qryAcc)
        begin
            addr_reg <= query.slaveAddr;
            func_reg <= query.funcCode;
            code_reg <= qryCode;
            exc_reg  <= qryExc;
        end
    end

    // Discard indication, one cycle per dropped query
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            dropped_reg <= 1'b0;
        else
            dropped_reg <= qryAcc && query.commError;
    end

    // Outgoing byte and its valid flag
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            txData_reg  <= 8'h00;
            txValid_reg <= 1'b0;
            payLast_reg <= 1'b0;
        end
        else
            unique case (state_reg)
                ST_IDLE:
                    if (qryAcc && !query.commError)
                    begin
                        txData_reg  <= query.slaveAddr;
                        txValid_reg <= 1'b1;
                    end
                ST_ADDR:
                    // echo function; exception sets top bit
                    if (fire)
                        txData_reg <= exc_reg ? (func_reg | EXC_FLAG)
                                              : func_reg;
                ST_FUNC:
                    if (fire)
                    begin
                        // single exception code in data field
                        txData_reg  <= code_reg;
                        txValid_reg <= exc_reg;
                    end
                ST_CODE:
                    if (fire)
                        txData_reg <= crcNext[7:0];
                ST_PAY:
                    if (!txValid_reg && payValid)
                    begin
                        txData_reg  <= payData;
                        txValid_reg <= 1'b1;
                        payLast_reg <= payLast;
                    end
                    else if (fire)
                    begin
                        txData_reg  <= crcNext[7:0];
                        txValid_reg <= payLast_reg;
                    end
                ST_CRCLO:
                    if (fire)
                        txData_reg <= crcVal[15:8];
                ST_CRCHI:
                    if (fire)
                        txValid_reg <= 1'b0;
            endcase
    end

    // CRC over address, function and data bytes
    modbus_crc16 #(
        .DATA_W  (BYTE_W)
    ) u_crc (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .init    (qryAcc),
        .update  (fire && (state_reg == ST_ADDR || state_reg == ST_FUNC
                  || state_reg == ST_CODE || state_reg == ST_PAY)),
        .dataIn  (txData_reg),
        .crcNext (crcNext),
        .crcVal  (crcVal)
    );

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    sequence sq_acc_good;
        qryAcc && !query.commError;
    endsequence

    sequence sq_exc_head;
        state_reg == ST_ADDR && fire && exc_reg;
    endsequence

    sequence sq_code_beat;
        state_reg == ST_CODE && fire;
    endsequence

    chk_drop_silent: assert property (
        qryAcc && query.commError |=> !txValid && queryReady && queryDropped)
        else $error("dropped query produced a reply");
    chk_addr_first: assert property (
        sq_acc_good |=> txValid && txData == $past(query.slaveAddr))
        else $error("reply did not open with slave address");
    chk_func_echo: assert property (
        state_reg == ST_ADDR && fire && !exc_reg |=> txData == func_reg)
        else $error("normal reply did not echo function");
    chk_func_plus80: assert property (
        sq_exc_head |=> txData[7] && txData[6:0] == func_reg[6:0] && txValid)
        else $error("exception function code not plus 80h");
    chk_code_only: assert property (
        state_reg == ST_CODE |-> txValid && txData == code_reg && exc_reg)
        else $error("exception data field not a single code");
    chk_code_then_crc: assert property (
        sq_code_beat |=> state_reg == ST_CRCLO)
        else $error("exception code not followed by CRC");
    chk_code_illfn: assert property (
        sq_acc_good and query.illegalFunc |=> code_reg == EXC_ILLEGAL_FUNC)
        else $error("illegal function not coded 01");
    chk_code_addr: assert property (
        sq_acc_good and (!query.illegalFunc && !query.funcCode[7]
        && query.badAddress) |=> code_reg == EXC_ILLEGAL_ADDR)
        else $error("bad address not coded 02");
    chk_code_value: assert property (
        sq_acc_good and (qryCode != EXC_ILLEGAL_FUNC && !query.badAddress
        && query.badValue) |=> code_reg == EXC_ILLEGAL_VALUE && exc_reg)
        else $error("bad value not coded 03");
    chk_code_ovf: assert property (
        sq_acc_good and (qryCode == EXC_BUF_OVERFLOW)
        |-> query.funcCode == FC_FILE_RECORD && query.bufferOverflow)
        else $error("overflow code outside function 20");
    chk_code_busy: assert property (
        sq_acc_good and (query.devBusy && qryCode == EXC_DEVICE_BUSY)
        |=> exc_reg && code_reg == 8'h06)
        else $error("busy not coded 06");
    chk_code_nak: assert property (
        sq_acc_good and (query.cannotProcess && qryCode == EXC_NEG_ACK)
        |=> exc_reg && code_reg == 8'h07)
        else $error("negative acknowledge not coded 07");
    chk_code_fail: assert property (
        sq_acc_good and (query.deviceFail && qryCode == EXC_DEVICE_FAIL)
        |=> exc_reg && code_reg == 8'h04)
        else $error("device failure not coded 04");
    chk_read_fail: assert property (
        sq_acc_good and (query.funcCode == 8'h03 && query.deviceFail
        && qryCode == EXC_DEVICE_FAIL)
        |=> exc_reg && func_reg == 8'h03 && code_reg == 8'h04)
        else $error("failed read not coded 04");
    chk_read_head: assert property (
        sq_exc_head and (func_reg == 8'h03) |=> txData == 8'h83)
        else $error("failed read reply not 83");
    chk_crc_bytes: assert property (
        state_reg == ST_CRCLO && fire
        |-> txData == crcVal[7:0] ##1 txData == crcVal[15:8] && txLast)
        else $error("CRC bytes wrong");

endmodule : modbus_slave_exception_responder

//--- test/master_model.sv
`timescale 1ns/1ps

module master_model
#(
    parameter int TMO = 16
)
(
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    input  wire logic [7:0] txData,
    input  wire logic       txValid,
    input  wire logic       txLast,
    output logic            txReady,
    input  wire logic       stall,
    output logic            timedOut,
    output logic            isExc
);
    logic [7:0] rxq[$];
    int         frames;
    int         lastIdx;
    int         idle;

    // Sink readiness, stalling every other cycle when asked
    always @(posedge sys_clk or negedge reset_n)
        if (!reset_n) txReady <= 1'b0;
        else txReady <= #1 stall ? ~txReady : 1'b1;

    // Collects reply bytes and notes where the frame ended
    always @(posedge sys_clk)
        if (reset_n && txValid && txReady)
        begin
            rxq.push_back(txData);
            if (txLast)
            begin
                lastIdx = rxq.size() - 1;
                frames++;
                isExc = rxq[1][7];
            end
        end

    always @(posedge sys_clk or negedge reset_n)
        if (!reset_n) idle <= 0;
        else if (txValid && txReady) idle <= 0;
        else if (idle < TMO) idle <= idle + 1;
    assign timedOut = (idle == TMO);
endmodule : master_model

//--- test/tb_top.sv
`timescale 1ns/1ps

module tb_top
    import modbus_exc_pkg::*;
;
    logic       sys_clk = 1'b0;
    logic       reset_n = 1'b0;
    query_s     query = '0;
    logic       queryValid = 1'b0;
    logic       queryReady;
    logic [7:0] payData = 8'h00;
    logic       payValid = 1'b0;
    logic       payLast = 1'b0;
    logic       payReady;
    logic [7:0] txData;
    logic       txValid;
    logic       txLast;
    logic       txReady;
    logic       queryDropped;
    logic       stall = 1'b0;
    logic       timedOut;
    logic       isExc;
    int         mismatches = 0;
    int         checks = 0;

    // Clock at 40 MHz
    always #12.5 sys_clk = ~sys_clk;

    modbus_slave_exception_responder uut (.sys_clk(sys_clk),
        .reset_n(reset_n), .query(query), .queryValid(queryValid),
        .queryReady(queryReady), .payData(payData), .payValid(payValid),
        .payLast(payLast), .payReady(payReady), .txData(txData),
        .txValid(txValid), .txLast(txLast), .txReady(txReady),
        .queryDropped(queryDropped));

    master_model mm (.sys_clk(sys_clk), .reset_n(reset_n),
        .txData(txData), .txValid(txValid), .txLast(txLast),
        .txReady(txReady), .stall(stall), .timedOut(timedOut),
        .isExc(isExc));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : print_verdict

    // Reply checksum, reflected polynomial over all bytes
    function automatic logic [15:0] crc16(input logic [7:0] b[$]);
        logic [15:0] c;
        c = CRC_INIT;
        foreach (b[i])
        begin
            c = c ^ {8'h00, b[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
        end
        return c;
    endfunction : crc16

    // Offers a query and holds it until the edge that takes it
    task automatic send_query(input query_s q);
        @(posedge sys_clk);
        #1;
        mm.rxq.delete();
        query = q;
        queryValid = 1'b1;
        @(negedge sys_clk);
        while (queryReady !== 1'b1) @(negedge sys_clk);
        @(posedge sys_clk);
        #1;
        queryValid = 1'b0;
    endtask : send_query

    // Offers one payload byte, left valid for the caller to release
    task automatic send_pay(input logic [7:0] d, input logic last);
        payData = d;
        payLast = last;
        payValid = 1'b1;
        @(negedge sys_clk);
        while (payReady !== 1'b1) @(negedge sys_clk);
        @(posedge sys_clk);
        #1;
    endtask : send_pay

    // Waits for a whole frame and compares it, checksum appended
    task automatic expect_frame(input logic [7:0] e[$], input int f0);
        logic [15:0] c;
        int          n;
        c = crc16(e);
        e.push_back(c[7:0]);
        e.push_back(c[15:8]);
        n = 0;
        while (mm.frames == f0 && n < 100)
        begin
            @(posedge sys_clk);
            n++;
        end
        #2;
        check(mm.rxq.size(), e.size());
        foreach (e[i]) check(mm.rxq[i], e[i]);
        check(mm.lastIdx, e.size() - 1);
    endtask : expect_frame

    // Every exception condition, back to back, some with stalls
    task automatic test_exceptions();
        logic [7:0] codes [9] = '{EXC_ILLEGAL_FUNC, EXC_ILLEGAL_ADDR,
            EXC_ILLEGAL_VALUE, EXC_DEVICE_FAIL, EXC_DEVICE_BUSY,
            EXC_NEG_ACK, EXC_BUF_OVERFLOW, EXC_ILLEGAL_FUNC,
            EXC_ILLEGAL_ADDR};
        query_s     q;
        int         f0;
        for (int i = 0; i < 9; i++)
        begin
            q = '0;
            q.slaveAddr = 8'h02;
            q.funcCode = 8'h03;
            case (i)
                0: q.illegalFunc = 1'b1;
                1: q.badAddress = 1'b1;
                2: q.badValue = 1'b1;
                3: q.deviceFail = 1'b1;
                4: q.devBusy = 1'b1;
                5: q.cannotProcess = 1'b1;
                6: q.funcCode = FC_FILE_RECORD;
                7: q.funcCode = 8'h83;
                default:
                begin
                    // Lower-ranked flags lose to the address fault
                    q.badAddress = 1'b1;
                    q.badValue = 1'b1;
                    q.devBusy = 1'b1;
                    q.deviceFail = 1'b1;
                end
            endcase
            q.bufferOverflow = (i == 6);
            stall = i[0];
            f0 = mm.frames;
            send_query(q);
            expect_frame('{8'h02, q.funcCode | EXC_FLAG, codes[i]}, f0);
            check(isExc, 1'b1);
        end
        stall = 1'b0;
    endtask : test_exceptions

    // Corrupted query draws no reply and the master times out
    task automatic test_dropped();
        query_s q;
        int     f0;
        int     seen;
        q = '0;
        q.slaveAddr = 8'h02;
        q.funcCode = 8'h03;
        q.commError = 1'b1;
        q.badAddress = 1'b1;
        f0 = mm.frames;
        seen = 0;
        send_query(q);
        repeat (3)
        begin
            @(negedge sys_clk);
            seen += (queryDropped === 1'b1);
        end
        check(seen, 1);
        repeat (20) @(posedge sys_clk);
        #2;
        check(mm.frames, f0);
        check(mm.rxq.size(), 0);
        check(timedOut, 1'b1);
    endtask : test_dropped

    // Normal reply echoes the function code, top bit clear
    task automatic test_normal();
        query_s q;
        int     f0;
        q = '0;
        q.slaveAddr = 8'h11;
        q.funcCode = 8'h03;
        q.bufferOverflow = 1'b1;
        stall = 1'b1;
        f0 = mm.frames;
        send_query(q);
        send_pay(8'hA5, 1'b0);
        send_pay(8'h3C, 1'b1);
        payValid = 1'b0;
        expect_frame('{8'h11, 8'h03, 8'hA5, 8'h3C}, f0);
        check(isExc, 1'b0);
        stall = 1'b0;
    endtask : test_normal

    // Watchdog on the whole run
    initial
    begin
        #(25 * 20000);
        mismatches++;
        print_verdict();
    end

    // Main sequence
    initial
    begin
        repeat (5) @(posedge sys_clk);
        check({queryReady, txValid, payReady}, 3'h4);
        #1;
        reset_n = 1'b1;
        test_exceptions();
        test_dropped();
        test_normal();
        print_verdict();
    end
endmodule : tb_top
